//--- rtl/fph_pkg.sv
// Shared constants, opcodes and mode type for the flash power, hold and reset control block
package fph_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing (times in ns, as the figures are given)
   localparam int FPH_CLK_PERIOD_NS = 20;                // Core clock, 50 MHz
   localparam int FPH_DEEP_SLEEP_ENTRY_TIME_NS = 3000;   // Longest entry into deep sleep
   localparam int FPH_DEEP_SLEEP_RESUME_TIME_NS = 8000;  // Longest resume from deep sleep
   localparam int FPH_ULTRA_SLEEP_ENTRY_TIME_NS = 3000;  // Longest entry into ultra sleep
   localparam int FPH_ULTRA_SLEEP_EXIT_TIME_NS = 70000;  // Longest exit from ultra sleep
   localparam int FPH_SOFT_RESET_TIME_NS = 30000;        // Longest program or erase termination
   localparam int FPH_TIMER_W = 12;                      // Countdown width, up to 4095 cycles

   // Longest time to whole cycles: rounds down, never below one cycle
   function automatic int fph_floor_cycles(input int ns);
      int cyc;
      cyc = ns / FPH_CLK_PERIOD_NS;
      return (cyc < 1) ? 1 : cyc;
   endfunction : fph_floor_cycles

   ////////////////////////////////////////////////////////////////////////////
   // Opcodes and fields
   localparam logic [7:0] FPH_OP_DEEP_SLEEP = 8'hB9;     // Enter deep sleep
   localparam logic [7:0] FPH_OP_RESUME = 8'hAB;         // Resume from deep sleep
   localparam logic [7:0] FPH_OP_ULTRA_SLEEP = 8'h79;    // Enter ultra sleep
   localparam logic [7:0] FPH_OP_SOFT_RESET = 8'hF0;     // Soft reset opcode
   localparam logic [7:0] FPH_OP_RESET_CONFIRM = 8'hD0;  // Soft reset confirmation byte
   localparam logic [7:0] FPH_OP_STATUS2_WRITE = 8'h31;  // Second status write
   localparam int FPH_PERMIT_BIT = 4;                    // Permit bit in status write data

   ////////////////////////////////////////////////////////////////////////////
   // Bit counting on the link
   localparam logic [7:0] FPH_BITS_ONE_BYTE = 8'h08;     // Count after the opcode
   localparam logic [7:0] FPH_BITS_TWO_BYTES = 8'h10;    // Count after the second byte
   localparam logic [7:0] FPH_BITS_SAT_TOP = 8'hFF;      // Highest count
   localparam logic [7:0] FPH_BITS_SAT_WRAP = 8'hF8;     // Wrap target, keeps byte phase
   localparam logic [7:0] FPH_BITS_RESET = 8'h00;        // Count value after reset
   localparam logic FPH_PERMIT_RESET = 1'b0;             // Reset permit after power-on

   ////////////////////////////////////////////////////////////////////////////
   // Power modes of the device
   typedef enum logic [2:0] {
      FPH_STANDBY,
      FPH_DEEP_ENTER,
      FPH_DEEP,
      FPH_DEEP_RESUME,
      FPH_ULTRA_ENTER,
      FPH_ULTRA,
      FPH_ULTRA_EXIT
   } fph_mode_t;

endpackage : fph_pkg

//--- rtl/fph_sync2.sv
// Two-stage level synchroniser into the core clock domain
module fph_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   // First stage, read only by the second stage
   logic [W-1:0] meta;

   ////////////////////////////////////////////////////////////////////////////
   // Both stages reset to the idle level of the signal
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule : fph_sync2

//--- rtl/fph_power_hold_reset_ctrl.sv
// Power-mode, hold and soft-reset command handling behind the serial flash link
//
// Behaviour
// - Deep sleep ignores everything except resume
// - Opcode B9h then deselect enters deep sleep
// - Short or misaligned deep sleep stays standby
// - Power-up always lands in standby
// - Sleep commands ignored while program/erase busy
// - Opcode ABh then deselect resumes standby
// - Short or misaligned resume stays asleep
// - Ultra sleep ignores every command
// - Opcode 79h enters ultra sleep unless busy
// - Select pulse exits ultra sleep, dummy ignored
// - Access during ultra exit time ignored
// - Early first bit exits but drops command
// - Power cycle restores all defaults
// - Hold never pauses program or erase
// - Hold starts only selected, at SCK low
// - Hold tristates output, ignores input and clock
// - Hold ends at SCK low
// - Deselect during hold aborts, clears write latch
// - Soft reset only while permit bit set
// - F0h D0h then deselect terminates operation
// - Status kept; latch cleared at termination only if busy and not sequential program
// - Soft reset needs both bytes, aligned end
// - Permit written by 31h bit 4 with latch
module fph_power_hold_reset_ctrl #(
   parameter int DEEP_ENTRY_NS = fph_pkg::FPH_DEEP_SLEEP_ENTRY_TIME_NS,
   parameter int DEEP_RESUME_NS = fph_pkg::FPH_DEEP_SLEEP_RESUME_TIME_NS,
   parameter int ULTRA_ENTRY_NS = fph_pkg::FPH_ULTRA_SLEEP_ENTRY_TIME_NS,
   parameter int ULTRA_EXIT_NS = fph_pkg::FPH_ULTRA_SLEEP_EXIT_TIME_NS,
   parameter int SOFT_RESET_NS = fph_pkg::FPH_SOFT_RESET_TIME_NS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic so_data,
   input wire logic so_drive_req,
   input wire logic busy,
   input wire logic sequential_prog,
   input wire logic write_enable_latch,
   output logic so,
   output logic so_oe,
   output logic hold_active,
   output logic in_standby,
   output logic in_deep_sleep,
   output logic in_ultra_sleep,
   output logic reset_command_permit,
   output logic op_terminate,
   output logic wel_clear
);
   import fph_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle counts derived from the times
   localparam int DEEP_ENTRY_CYC = fph_floor_cycles(DEEP_ENTRY_NS);
   localparam int DEEP_RESUME_CYC = fph_floor_cycles(DEEP_RESUME_NS);
   localparam int ULTRA_ENTRY_CYC = fph_floor_cycles(ULTRA_ENTRY_NS);
   localparam int ULTRA_EXIT_CYC = fph_floor_cycles(ULTRA_EXIT_NS);
   localparam int SOFT_RESET_CYC = fph_floor_cycles(SOFT_RESET_NS);
   localparam logic [FPH_TIMER_W-1:0] DEEP_ENTRY_CNT = FPH_TIMER_W'(DEEP_ENTRY_CYC);
   localparam logic [FPH_TIMER_W-1:0] DEEP_RESUME_CNT = FPH_TIMER_W'(DEEP_RESUME_CYC);
   localparam logic [FPH_TIMER_W-1:0] ULTRA_ENTRY_CNT = FPH_TIMER_W'(ULTRA_ENTRY_CYC);
   localparam logic [FPH_TIMER_W-1:0] ULTRA_EXIT_CNT = FPH_TIMER_W'(ULTRA_EXIT_CYC);
   localparam logic [FPH_TIMER_W-1:0] SOFT_RESET_CNT = FPH_TIMER_W'(SOFT_RESET_CYC);
   localparam logic [FPH_TIMER_W-1:0] TIMER_ONE = FPH_TIMER_W'(1);
   localparam logic [FPH_TIMER_W-1:0] TIMER_ZERO = '0;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: shift register and framing, clocked by SCK
   typedef struct packed {
      logic [7:0] shreg;  // Incoming bits, first bit ends up in bit 7
      logic [7:0] op;     // First byte of the frame
      logic [7:0] conf;   // Second byte of the frame
      logic [7:0] cnt;    // Bits in the frame, wraps keeping byte phase
      logic tgl;          // Flips on the first bit of every frame
   } fph_link_t;

   fph_link_t link;       // Link state
   fph_link_t next_link;  // Link state next value
   logic frame_fresh;     // No bit taken yet in this selection
   logic hold_lat;        // Hold seen at the last SCK rise
   logic hold_eff;        // Hold in force right now

   // Marks the start of each selection; cleared by the first taken bit
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         frame_fresh <= 1'b1;
      end else if (hold_n) begin
         frame_fresh <= 1'b0;
      end
   end

   // Bits shift only while not held, so framing survives a pause
   always_comb begin
      next_link = link;
      if (hold_n) begin
         next_link.shreg = {link.shreg[6:0], si};
         if (frame_fresh) begin
            next_link.cnt = FPH_BITS_ONE_BYTE - 8'h07;
            next_link.tgl = ~link.tgl;
         end else if (link.cnt == FPH_BITS_SAT_TOP) begin
            next_link.cnt = FPH_BITS_SAT_WRAP;  // Keeps multiple-of-eight test valid on long frames
         end else begin
            next_link.cnt = link.cnt + 8'h01;
         end
         if (next_link.cnt == FPH_BITS_ONE_BYTE) begin
            next_link.op = next_link.shreg;
         end
         if (next_link.cnt == FPH_BITS_TWO_BYTES) begin
            next_link.conf = next_link.shreg;
         end
      end
   end

   // Link registers; data stays put while deselected for the core to read
   always_ff @(posedge sck or negedge reset_n) begin
      if (!reset_n) begin
         link <= '0;
      end else begin
         link <= next_link;
      end
   end

   // Hold level at the end of the low phase, kept through the high phase
   always_ff @(posedge sck or negedge reset_n) begin
      if (!reset_n) begin
         hold_lat <= 1'b0;
      end else begin
         hold_lat <= ~hold_n;
      end
   end

   // Low phase follows the pin at once, high phase keeps the level from the rise
   assign hold_eff = ~cs_n & (sck ? hold_lat : ~hold_n);
   assign hold_active = hold_eff;

   ////////////////////////////////////////////////////////////////////////////
   // Crossing into the core domain
   logic cs_n_s;    // Select, synchronised
   logic hold_n_s;  // Hold, synchronised
   logic tgl_s;     // First-bit toggle, synchronised

   // The frame bytes and count are only read while select is high,
   // when SCK is quiet, so the synchronised select qualifies them
   fph_sync2 #(
      .W(3),
      .RESET_VAL(3'b110)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({cs_n, hold_n, link.tgl}),
      .q({cs_n_s, hold_n_s, tgl_s})
   );

   ////////////////////////////////////////////////////////////////////////////
   // Core domain: power modes, permit bit and soft reset
   typedef struct packed {
      fph_mode_t mode;                // Power mode
      logic [FPH_TIMER_W-1:0] timer;  // Countdown for mode changes and reset
      logic cs_n_q;                   // Select, one cycle later
      logic tgl_seen;                 // Toggle value at the last frame end
      logic frame_ok;                 // Frame may be decoded
      logic permit;                   // Soft reset allowed
      logic reset_act;                // Termination in progress
      logic wel_clr_pend;             // Clear write latch when termination ends
      logic wel_clear;                // One-cycle write latch clear
   } fph_ctrl_t;

   fph_ctrl_t st;       // Core state
   fph_ctrl_t next_st;  // Core state next value
   logic cs_rise;       // Select released
   logic cs_fall;       // Select taken
   logic has_bits;      // Frame carried at least one bit
   logic aligned;       // Frame ended on a byte boundary
   logic got_one;       // Whole opcode received
   logic got_two;       // Opcode and second byte received
   logic decode;        // Frame end to act on
   logic hold_abort;    // Released while hold still asserted

   assign cs_rise = cs_n_s & ~st.cs_n_q;
   assign cs_fall = ~cs_n_s & st.cs_n_q;
   assign has_bits = tgl_s ^ st.tgl_seen;
   assign aligned = (link.cnt[2:0] == 3'h0);
   assign got_one = (link.cnt >= FPH_BITS_ONE_BYTE);
   assign got_two = (link.cnt >= FPH_BITS_TWO_BYTES);
   assign hold_abort = cs_rise & ~hold_n_s;
   assign decode = cs_rise & st.frame_ok & has_bits & ~hold_abort;

   // Mode sequencing and command decode at each frame end
   always_comb begin
      next_st = st;
      next_st.cs_n_q = cs_n_s;
      next_st.wel_clear = 1'b0;
      if (cs_rise) begin
         next_st.tgl_seen = tgl_s;
      end
      // Frames that start in standby or deep sleep may be decoded
      if (cs_fall) begin
         next_st.frame_ok = (st.mode == FPH_STANDBY) || (st.mode == FPH_DEEP);
      end
      // Termination countdown; program and erase keep running under hold
      if (st.reset_act) begin
         if (st.timer == TIMER_ONE) begin
            next_st.reset_act = 1'b0;
            next_st.wel_clear = st.wel_clr_pend;
            next_st.wel_clr_pend = 1'b0;
         end else begin
            next_st.timer = st.timer - TIMER_ONE;
         end
      end
      case (st.mode)
         FPH_STANDBY: begin
            if (decode && !st.reset_act) begin
               if (link.op == FPH_OP_DEEP_SLEEP && got_one && aligned && !busy) begin
                  next_st.mode = FPH_DEEP_ENTER;
                  next_st.timer = DEEP_ENTRY_CNT;
               end else if (link.op == FPH_OP_ULTRA_SLEEP && got_one && !busy) begin
                  next_st.mode = FPH_ULTRA_ENTER;
                  next_st.timer = ULTRA_ENTRY_CNT;
               end else if (link.op == FPH_OP_SOFT_RESET && link.conf == FPH_OP_RESET_CONFIRM &&
                            got_two && aligned && st.permit) begin
                  next_st.reset_act = 1'b1;
                  next_st.timer = SOFT_RESET_CNT;
                  next_st.wel_clr_pend = busy & ~sequential_prog;
               end else if (link.op == FPH_OP_STATUS2_WRITE && got_one) begin
                  // Any attempt clears the latch; only a full aligned one writes
                  if (got_two && aligned && write_enable_latch) begin
                     next_st.permit = link.conf[FPH_PERMIT_BIT];
                  end
                  next_st.wel_clear = 1'b1;
               end
            end
         end
         FPH_DEEP_ENTER: begin
            if (st.timer == TIMER_ONE) begin
               next_st.mode = FPH_DEEP;
            end else begin
               next_st.timer = st.timer - TIMER_ONE;
            end
         end
         FPH_DEEP: begin
            // Anything but a whole, aligned resume leaves the mode alone
            if (decode && link.op == FPH_OP_RESUME && got_one && aligned) begin
               next_st.mode = FPH_DEEP_RESUME;
               next_st.timer = DEEP_RESUME_CNT;
            end
         end
         FPH_DEEP_RESUME: begin
            if (st.timer == TIMER_ONE) begin
               next_st.mode = FPH_STANDBY;
            end else begin
               next_st.timer = st.timer - TIMER_ONE;
            end
         end
         FPH_ULTRA_ENTER: begin
            if (st.timer == TIMER_ONE) begin
               next_st.mode = FPH_ULTRA;
            end else begin
               next_st.timer = st.timer - TIMER_ONE;
            end
         end
         FPH_ULTRA: begin
            // Only the select edge matters here; bits are never decoded
            if (cs_fall) begin
               next_st.mode = FPH_ULTRA_EXIT;
               next_st.timer = ULTRA_EXIT_CNT;
               next_st.frame_ok = 1'b0;
            end
         end
         FPH_ULTRA_EXIT: begin
            if (cs_rise) begin
               // Toggle exit: full exit time counted from the release
               next_st.timer = ULTRA_EXIT_CNT;
            end else if (st.timer == TIMER_ONE) begin
               next_st.mode = FPH_STANDBY;
               // Still selected with no bit yet: the coming command counts
               next_st.frame_ok = ~cs_n_s & ~has_bits;
            end else begin
               next_st.timer = st.timer - TIMER_ONE;
            end
         end
         default: begin
            next_st.mode = FPH_STANDBY;
         end
      endcase
      if (hold_abort) begin
         next_st.wel_clear = 1'b1;
      end
   end

   // Power-on reset is the only way out of ultra sleep besides the select
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st.mode <= FPH_STANDBY;
         st.timer <= TIMER_ZERO;
         st.cs_n_q <= 1'b1;
         st.tgl_seen <= 1'b0;
         st.frame_ok <= 1'b0;
         st.permit <= FPH_PERMIT_RESET;
         st.reset_act <= 1'b0;
         st.wel_clr_pend <= 1'b0;
         st.wel_clear <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign in_standby = (st.mode == FPH_STANDBY);
   assign in_deep_sleep = (st.mode == FPH_DEEP);
   assign in_ultra_sleep = (st.mode == FPH_ULTRA);
   assign reset_command_permit = st.permit;
   assign op_terminate = st.reset_act;
   assign wel_clear = st.wel_clear;
   assign so = so_data;
   // Output driven only when selected, not held and awake; this gates an
   // enable, not a state, so the async mix only shapes a pin drive window
   assign so_oe = so_drive_req & ~cs_n & ~hold_eff & in_standby;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   localparam int A_DEEP_ENTRY = DEEP_ENTRY_CYC;
   localparam int A_DEEP_RESUME = DEEP_RESUME_CYC;
   localparam int A_SOFT_RESET = SOFT_RESET_CYC;

   property p_deep_only_resume;
      @(posedge clk) disable iff (!reset_n)
         (st.mode == FPH_DEEP && decode && link.op != FPH_OP_RESUME) |=> (st.mode == FPH_DEEP);
   endproperty
   a_deep_only_resume: assert property (p_deep_only_resume) else $error("deep sleep left by non-resume");

   property p_deep_entry;
      @(posedge clk) disable iff (!reset_n)
         $rose(st.mode == FPH_DEEP_ENTER) |-> ##[1:A_DEEP_ENTRY] (st.mode == FPH_DEEP);
   endproperty
   a_deep_entry: assert property (p_deep_entry) else $error("deep sleep entry too slow");

   property p_misaligned_stays;
      @(posedge clk) disable iff (!reset_n)
         (st.mode == FPH_STANDBY && decode && !aligned && link.op == FPH_OP_DEEP_SLEEP)
            |=> (st.mode == FPH_STANDBY);
   endproperty
   a_misaligned_stays: assert property (p_misaligned_stays) else $error("misaligned deep sleep taken");

   property p_power_up;
      @(posedge clk) $rose(reset_n) |-> (st.mode == FPH_STANDBY && !st.permit);
   endproperty
   a_power_up: assert property (p_power_up) else $error("not standby after reset");

   property p_busy_blocks;
      @(posedge clk) disable iff (!reset_n)
         (st.mode == FPH_STANDBY && decode && busy) |=> (st.mode == FPH_STANDBY);
   endproperty
   a_busy_blocks: assert property (p_busy_blocks) else $error("sleep entered while busy");

   property p_resume;
      @(posedge clk) disable iff (!reset_n)
         $rose(st.mode == FPH_DEEP_RESUME) |-> ##[1:A_DEEP_RESUME] (st.mode == FPH_STANDBY);
   endproperty
   a_resume: assert property (p_resume) else $error("resume too slow");

   property p_ultra_ignores;
      @(posedge clk) disable iff (!reset_n)
         (st.mode == FPH_ULTRA && !cs_fall) |=> (st.mode == FPH_ULTRA);
   endproperty
   a_ultra_ignores: assert property (p_ultra_ignores) else $error("ultra sleep left without select");

   property p_hold_abort;
      @(posedge clk) disable iff (!reset_n)
         hold_abort |=> (st.wel_clear && $stable(st.mode));
   endproperty
   a_hold_abort: assert property (p_hold_abort) else $error("hold abort did not clear latch");

   property p_reset_gated;
      @(posedge clk) disable iff (!reset_n)
         $rose(st.reset_act) |-> $past(st.permit);
   endproperty
   a_reset_gated: assert property (p_reset_gated) else $error("soft reset without permit");

   property p_reset_ends;
      @(posedge clk) disable iff (!reset_n)
         $rose(st.reset_act) |-> ##[1:A_SOFT_RESET] !st.reset_act;
   endproperty
   a_reset_ends: assert property (p_reset_ends) else $error("termination overran");

endmodule : fph_power_hold_reset_ctrl

//--- sim/fph_host.sv
// Host link controller model: frames of bits on cs_n, sck, si and hold_n
module fph_host;
   timeunit 1ns;
   timeprecision 1ps;
   logic sck = 1'b0; // Stands still low outside frames
   logic cs_n = 1'b1; // Idle deselected
   logic si = 1'b0; // Serial data to device
   logic hold_n = 1'b1; // Hold pin, idle released

   ////////////////////////////////////////////////////////////////////////////
   // One framed access; bits MSB first, optional hold pause or hold at deselect
   task automatic frame(input logic [15:0] d, input int n, input int hold_at, input bit hold_end);
      cs_n = 1'b0;
      #60;
      for (int i = 0; i < n; i++) begin
         if (i == hold_at) begin
            // Hold taken while sck low, then one ignored clock pulse
            hold_n = 1'b0;
            si = ~si;
            #15 sck = 1'b1;
            #15 sck = 1'b0;
            #15 hold_n = 1'b1;
            #15;
         end
         si = d[15-i];
         #15 sck = 1'b1;
         #15 sck = 1'b0;
      end
      // Released data line shows the inverse of the last bit until 40 ns after deselect
      si = ~si;
      if (hold_end) begin
         hold_n = 1'b0;
      end
      #20 cs_n = 1'b1;
      #40 hold_n = 1'b1;
      si = ~si;
      #100;
   endtask : frame
endmodule : fph_host

//--- sim/tb.sv
// Self-checking bench for the power, hold and soft-reset block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fph_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, so_data = 1'b0, so_drive_req = 1'b0;
   logic busy = 1'b0, sequential_prog = 1'b0, write_enable_latch = 1'b0;
   logic so, so_oe, hold_active, in_standby, in_deep_sleep, in_ultra_sleep;
   logic reset_command_permit, op_terminate, wel_clear, term_q;
   int n_fail = 0, checks = 0, cyc = 0, n_term = 0, n_wc = 0;
   int exp_mode = 0, exp_term = 0, exp_wc = 0; // Model: 0 standby, 1 deep, 2 ultra
   logic exp_permit = 1'b0;
   int prev_mode = 0; // Model mode during the coming frame, -1 when it changes inside it
   logic hold_exp; // Model hold state for the current sck high phase

   always #10 clk = ~clk;
   fph_host u_host();
   // Short timers (10 cycles) keep the run brief; the ultra exit (20) outlasts a one-byte frame
   fph_power_hold_reset_ctrl #(.DEEP_ENTRY_NS(200), .DEEP_RESUME_NS(200), .ULTRA_ENTRY_NS(200),
      .ULTRA_EXIT_NS(400), .SOFT_RESET_NS(200)) uut (.clk(clk), .reset_n(reset_n), .sck(u_host.sck),
      .cs_n(u_host.cs_n), .si(u_host.si), .hold_n(u_host.hold_n), .so_data(so_data),
      .so_drive_req(so_drive_req), .busy(busy), .sequential_prog(sequential_prog),
      .write_enable_latch(write_enable_latch), .so(so), .so_oe(so_oe), .hold_active(hold_active),
      .in_standby(in_standby), .in_deep_sleep(in_deep_sleep), .in_ultra_sleep(in_ultra_sleep),
      .reset_command_permit(reset_command_permit), .op_terminate(op_terminate), .wel_clear(wel_clear));

   ////////////////////////////////////////////////////////////////////////////
   // Pulse counters and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      term_q <= op_terminate;
      if (op_terminate === 1'b1 && term_q !== 1'b1) n_term <= n_term + 1;
      if (wel_clear === 1'b1) n_wc <= n_wc + 1;
      so_data <= 1'($urandom);
      so_drive_req <= 1'($urandom);
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         final_report();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk

   // Mid high phase of each link clock: hold keeps the level seen at the rise
   always @(posedge u_host.sck) begin
      hold_exp = !u_host.cs_n && !u_host.hold_n;
      #7;
      chk("hold_active", hold_active, hold_exp);
      if (prev_mode >= 0) chk("so_oe", so_oe, so_drive_req && !hold_exp && prev_mode == 0);
   end

   // Frame, settle, then compare every result against the model
   task automatic run(input logic [15:0] d, input int n, input int h = -1, input bit he = 1'b0);
      u_host.frame(d, n, h, he);
      repeat (40) @(posedge clk);
      chk("standby", in_standby, exp_mode == 0);
      chk("deep", in_deep_sleep, exp_mode == 1);
      chk("ultra", in_ultra_sleep, exp_mode == 2);
      chk("permit", reset_command_permit, exp_permit);
      chk("terms", n_term, exp_term);
      chk("wel_clears", n_wc, exp_wc);
      chk("so", so, so_data);
      prev_mode = exp_mode;
   endtask : run

   task automatic final_report();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h1522));
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      run(16'h0000, 0);
      busy <= 1'b1;
      run({FPH_OP_DEEP_SLEEP, 8'h00}, 8);
      busy <= 1'b0;
      run({FPH_OP_DEEP_SLEEP, 8'h00}, 7);
      run({FPH_OP_DEEP_SLEEP, 8'h00}, 9);
      run({FPH_OP_SOFT_RESET, FPH_OP_RESET_CONFIRM}, 16);
      exp_wc++;
      run({FPH_OP_STATUS2_WRITE, 8'h10}, 16);
      write_enable_latch <= 1'b1;
      exp_wc++;
      exp_permit = 1'b1;
      run({FPH_OP_STATUS2_WRITE, 8'h10}, 16);
      busy <= 1'b1;
      run({FPH_OP_SOFT_RESET, FPH_OP_RESET_CONFIRM}, 12);
      exp_term++;
      exp_wc++;
      run({FPH_OP_SOFT_RESET, FPH_OP_RESET_CONFIRM}, 16);
      sequential_prog <= 1'b1;
      exp_term++;
      run({FPH_OP_SOFT_RESET, FPH_OP_RESET_CONFIRM}, 16);
      sequential_prog <= 1'b0;
      busy <= 1'b0;
      exp_mode = 1;
      run({FPH_OP_DEEP_SLEEP, 8'($urandom)}, 16, 3);
      run({FPH_OP_ULTRA_SLEEP, 8'h00}, 8);
      run({FPH_OP_RESUME, 8'h00}, 7);
      exp_mode = 0;
      run({FPH_OP_RESUME, 8'($urandom)}, 16);
      exp_mode = 2;
      run({FPH_OP_ULTRA_SLEEP, 8'h00}, 8);
      u_host.frame({FPH_OP_RESUME, 8'h00}, 8, -1, 1'b0);
      prev_mode = -1;
      exp_mode = 0;
      run({FPH_OP_DEEP_SLEEP, 8'h00}, 8);
      exp_mode = 2;
      run({FPH_OP_ULTRA_SLEEP, 8'h00}, 8);
      exp_mode = 0;
      run({FPH_OP_DEEP_SLEEP, 8'h00}, 8);
      exp_wc++;
      run({FPH_OP_DEEP_SLEEP, 8'h00}, 8, -1, 1'b1);
      exp_mode = 2;
      run({FPH_OP_ULTRA_SLEEP, 8'h00}, 8);
      reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      exp_mode = 0;
      exp_permit = 1'b0;
      run(16'h0000, 0);
      final_report();
   end
endmodule : tb
